// [hw/fsq_cmd_core.sv]
// Purpose: security register, quad mode, read parameter and lock commands
// Assumes: sclk_i is the host serial clock, idle between frames
// Notes: link logic on sclk_i, lock bits and status outputs on ref_clk_i
`timescale 1ns/1ps
`include "fsq_consts.svh"

module fsq_cmd_core #(
  parameter int NUM_UNITS = 128,
  parameter int UNIT_BITS = 7
) (
  // core clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // serial link
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic [3:0] io_i,
  output logic [3:0] io_o,
  output logic [3:0] io_oe_o,
  // status from the rest of the device (core domain levels)
  input wire logic write_enable_latch_flag_i,
  input wire logic busy_i,
  input wire logic quad_enable_bit_i,
  input wire logic [2:0] otp_lock_bits_i,
  input wire logic protect_scheme_select_i,
  input wire logic legacy_protect_i,
  // main array read port (link domain)
  output logic [23:0] array_addr_o,
  input wire logic [7:0] array_data_i,
  // protection query (core domain)
  input wire logic [UNIT_BITS-1:0] query_unit_i,
  output logic write_protected_o,
  // configuration seen by the core
  output logic quad_command_mode_o,
  output logic [1:0] dummy_count_field_o,
  output logic [1:0] wrap_size_field_o
);

  // -----------------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------------
  // clocks needed for a number of bits at one or four bits per clock
  function automatic logic [5:0] fsq_clocks(input logic [5:0] bits, input logic quad);
    fsq_clocks = quad ? (bits >> 2) : bits;
  endfunction

  // dummy count code to clocks: 2, 4, 6, 8
  function automatic logic [5:0] fsq_dummy_clocks(input logic [1:0] sel);
    fsq_dummy_clocks = {3'h0, sel, 1'b0} + 6'h02;
  endfunction

  // wrap code to window mask: 8, 16, 32, 64 bytes less one
  function automatic logic [23:0] fsq_wrap_mask(input logic [1:0] sel);
    fsq_wrap_mask = (24'h00_0008 << sel) - 24'h00_0001;
  endfunction

  // -----------------------------------------------------------------------
  // core-side status brought into the link domain
  // -----------------------------------------------------------------------
  logic [5:0] st_meta_reg;
  logic [5:0] st_sync_reg;
  logic wel_s;
  logic busy_s;
  logic qe_s;
  logic [2:0] otp_s;

  // plain two-flop synchronisers; the levels change only between frames
  always_ff @(posedge sclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_meta_reg <= 6'h00;
      st_sync_reg <= 6'h00;
    end
    else
    begin
      st_meta_reg <= {write_enable_latch_flag_i, busy_i, quad_enable_bit_i, otp_lock_bits_i};
      st_sync_reg <= st_meta_reg;
    end
  end

  assign {wel_s, busy_s, qe_s, otp_s} = st_sync_reg;

  // -----------------------------------------------------------------------
  // link frame state, cleared whenever select is high
  // -----------------------------------------------------------------------
  logic frame_rst;
  fsq_pkg::fsq_state_type st_reg, st_next;
  fsq_pkg::fsq_cmd_type cmd_reg, cmd_next;
  logic [5:0] cnt_reg, cnt_next;
  logic [5:0] plen_reg, plen_next;
  logic [23:0] sh_reg, sh_next;
  logic [23:0] addr_reg, addr_next;
  logic [8:0] nbytes_reg, nbytes_next;
  logic [1:0] sel_reg, sel_next;
  fsq_pkg::fsq_cfg_type cfg_reg, cfg_next;
  logic cfg_tog_reg, cfg_tog_next;
  logic lock_tog_reg, lock_tog_next;
  logic [23:0] lock_addr_reg, lock_addr_next;
  logic [7:0] sec_mem [0:767];
  logic mem_we;
  logic [9:0] mem_widx;
  logic [7:0] mem_wdata;
  logic [7:0] sec_byte;
  logic [7:0] out_byte;
  logic [5:0] cnt_inc;
  logic done;
  logic sec_ok;
  logic ev_enter, ev_exit, ev_param, ev_spiwrap, ev_lock;
  logic [7:0] ev_byte;
  logic [23:0] wmask;

  assign frame_rst = rst_i | cs_n_i;
  assign cnt_inc = cnt_reg + 6'h01;
  assign done = (cnt_inc == plen_reg);
  assign wmask = fsq_wrap_mask(cfg_reg.wrap_sel);
  assign sec_byte = sec_mem[{sel_reg, addr_reg[`FSQ_ADDR_BYTE_HI:`FSQ_ADDR_BYTE_LO]}];
  assign out_byte = (cmd_reg == fsq_pkg::CMD_READ_SEC) ? sec_byte : array_data_i;
  assign array_addr_o = addr_reg;

  // security register address must name register 1..3 with zero fields
  always_comb
  begin
    sec_ok = (sh_next[`FSQ_ADDR_TOP_HI:`FSQ_ADDR_TOP_LO] == 8'h00)
          && (sh_next[`FSQ_ADDR_ZERO_HI:`FSQ_ADDR_ZERO_LO] == 4'h0)
          && (sh_next[`FSQ_ADDR_SEL_HI:`FSQ_ADDR_SEL_LO] != 4'h0)
          && (sh_next[`FSQ_ADDR_SEL_HI:`FSQ_ADDR_SEL_LO] <= 4'h3);
  end

  // next values of the frame interpreter
  always_comb
  begin
    st_next = st_reg;
    cmd_next = cmd_reg;
    cnt_next = cnt_inc;
    plen_next = plen_reg;
    addr_next = addr_reg;
    nbytes_next = nbytes_reg;
    sel_next = sel_reg;
    mem_we = 1'b0;
    mem_widx = 10'h000;
    mem_wdata = 8'h00;
    ev_enter = 1'b0;
    ev_exit = 1'b0;
    ev_param = 1'b0;
    ev_spiwrap = 1'b0;
    ev_lock = 1'b0;
    // four lines per clock in quad mode, data input only otherwise
    sh_next = cfg_reg.quad_mode ? {sh_reg[19:0], io_i} : {sh_reg[22:0], io_i[0]};
    ev_byte = sh_next[7:0];
    case (st_reg)
      fsq_pkg::ST_OPCODE:
      begin
        if (done)
        begin
          cnt_next = 6'h00;
          st_next = fsq_pkg::ST_IGNORE;
          plen_next = fsq_clocks(`FSQ_BITS_ADDR, cfg_reg.quad_mode);
          if (sh_next[7:0] == `FSQ_OP_PROG_SEC && !cfg_reg.quad_mode)
          begin
            cmd_next = fsq_pkg::CMD_PROG_SEC;
            st_next = fsq_pkg::ST_ADDR;
          end
          else if (sh_next[7:0] == `FSQ_OP_READ_SEC && !cfg_reg.quad_mode && !busy_s)
          begin
            cmd_next = fsq_pkg::CMD_READ_SEC;
            st_next = fsq_pkg::ST_ADDR;
          end
          else if (sh_next[7:0] == `FSQ_OP_SET_PARAM && cfg_reg.quad_mode)
          begin
            cmd_next = fsq_pkg::CMD_SET_PARAM;
            st_next = fsq_pkg::ST_PARAM;
            plen_next = fsq_clocks(`FSQ_BITS_BYTE, cfg_reg.quad_mode);
          end
          else if ((sh_next[7:0] == `FSQ_OP_WRAP_SDR || sh_next[7:0] == `FSQ_OP_WRAP_DTR) && cfg_reg.quad_mode)
          begin
            cmd_next = fsq_pkg::CMD_WRAP_READ;
            st_next = fsq_pkg::ST_ADDR;
          end
          else if (sh_next[7:0] == `FSQ_OP_LOCK)
          begin
            cmd_next = fsq_pkg::CMD_LOCK;
            st_next = fsq_pkg::ST_ADDR;
          end
          else if (sh_next[7:0] == `FSQ_OP_SET_WRAP && !cfg_reg.quad_mode)
          begin
            cmd_next = fsq_pkg::CMD_SET_WRAP;
            st_next = fsq_pkg::ST_ADDR;
          end
          else if (sh_next[7:0] == `FSQ_OP_ENTER_QUAD && !cfg_reg.quad_mode)
          begin
            ev_enter = qe_s;
          end
          else if (sh_next[7:0] == `FSQ_OP_EXIT_QUAD && cfg_reg.quad_mode)
          begin
            ev_exit = 1'b1;
          end
        end
      end
      fsq_pkg::ST_ADDR:
      begin
        if (done)
        begin
          cnt_next = 6'h00;
          addr_next = sh_next;
          sel_next = 2'(sh_next[`FSQ_ADDR_SEL_LO+1:`FSQ_ADDR_SEL_LO] - 2'h1);
          nbytes_next = 9'h000;
          st_next = fsq_pkg::ST_IGNORE;
          plen_next = fsq_clocks(`FSQ_BITS_BYTE, cfg_reg.quad_mode);
          case (cmd_reg)
            fsq_pkg::CMD_PROG_SEC:
            begin
              // locked register or missing latch: swallow the data
              if (sec_ok && wel_s && !busy_s
                  && !otp_s[2'(sh_next[`FSQ_ADDR_SEL_LO+1:`FSQ_ADDR_SEL_LO] - 2'h1)])
              begin
                st_next = fsq_pkg::ST_DATA_IN;
              end
            end
            fsq_pkg::CMD_READ_SEC:
            begin
              if (sec_ok)
              begin
                st_next = fsq_pkg::ST_DUMMY;
                plen_next = `FSQ_SEC_DUMMY;
              end
            end
            fsq_pkg::CMD_WRAP_READ:
            begin
              st_next = fsq_pkg::ST_DUMMY;
              plen_next = fsq_dummy_clocks(cfg_reg.dummy_sel);
            end
            fsq_pkg::CMD_LOCK:
            begin
              ev_lock = wel_s && !busy_s;
            end
            fsq_pkg::CMD_SET_WRAP:
            begin
              st_next = fsq_pkg::ST_PARAM;
            end
            default:
            begin
              st_next = fsq_pkg::ST_IGNORE;
            end
          endcase
        end
      end
      fsq_pkg::ST_DUMMY:
      begin
        if (done)
        begin
          cnt_next = 6'h00;
          st_next = fsq_pkg::ST_DATA_OUT;
          plen_next = fsq_clocks(`FSQ_BITS_BYTE, cfg_reg.quad_mode);
        end
      end
      fsq_pkg::ST_DATA_IN:
      begin
        if (done)
        begin
          cnt_next = 6'h00;
          nbytes_next = nbytes_reg + 9'h001;
          addr_next[`FSQ_ADDR_BYTE_HI:`FSQ_ADDR_BYTE_LO] = addr_reg[`FSQ_ADDR_BYTE_HI:`FSQ_ADDR_BYTE_LO] + 8'h01;
          // only erased bytes take data; later bytes are dropped
          mem_we = (sec_byte == `FSQ_ERASED);
          mem_widx = {sel_reg, addr_reg[`FSQ_ADDR_BYTE_HI:`FSQ_ADDR_BYTE_LO]};
          mem_wdata = sh_next[7:0];
          if (nbytes_next == `FSQ_SEC_BYTES)
          begin
            st_next = fsq_pkg::ST_IGNORE;
          end
        end
      end
      fsq_pkg::ST_DATA_OUT:
      begin
        if (done)
        begin
          cnt_next = 6'h00;
          if (cmd_reg == fsq_pkg::CMD_READ_SEC)
          begin
            // 8-bit byte field rolls FFh to 00h in the same register
            addr_next[`FSQ_ADDR_BYTE_HI:`FSQ_ADDR_BYTE_LO] = addr_reg[`FSQ_ADDR_BYTE_HI:`FSQ_ADDR_BYTE_LO] + 8'h01;
          end
          else
          begin
            addr_next = (addr_reg & ~wmask) | ((addr_reg + 24'h00_0001) & wmask);
          end
        end
      end
      fsq_pkg::ST_PARAM:
      begin
        if (done)
        begin
          cnt_next = 6'h00;
          st_next = fsq_pkg::ST_IGNORE;
          ev_param = (cmd_reg == fsq_pkg::CMD_SET_PARAM);
          ev_spiwrap = (cmd_reg == fsq_pkg::CMD_SET_WRAP);
        end
      end
      default:
      begin
        cnt_next = 6'h00; // ignore the rest of the frame
      end
    endcase
  end

  // frame registers; select high restarts at the opcode
  always_ff @(posedge sclk_i or posedge frame_rst)
  begin
    if (frame_rst)
    begin
      st_reg <= fsq_pkg::ST_OPCODE;
      cmd_reg <= fsq_pkg::CMD_NONE;
      cnt_reg <= 6'h00;
      plen_reg <= `FSQ_BITS_OPCODE;
      sh_reg <= 24'h00_0000;
      addr_reg <= 24'h00_0000;
      nbytes_reg <= 9'h000;
      sel_reg <= 2'h0;
    end
    else
    begin
      st_reg <= st_next;
      cmd_reg <= cmd_next;
      cnt_reg <= cnt_next;
      // opcode length follows the mode in force for the next frame
      plen_reg <= (st_reg == fsq_pkg::ST_OPCODE && !done) ? fsq_clocks(`FSQ_BITS_OPCODE, cfg_reg.quad_mode) : plen_next;
      sh_reg <= sh_next;
      addr_reg <= addr_next;
      nbytes_reg <= nbytes_next;
      sel_reg <= sel_next;
    end
  end

  // security register storage; power-up shows the factory erased state
  always_ff @(posedge sclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < 768; i++)
      begin
        sec_mem[i] <= `FSQ_ERASED;
      end
    end
    else if (mem_we)
    begin
      sec_mem[mem_widx] <= mem_wdata;
    end
  end

  // -----------------------------------------------------------------------
  // persistent link configuration and requests to the core
  // -----------------------------------------------------------------------
  // mode switches touch only the mode bit, so latch and wrap survive
  always_comb
  begin
    cfg_next = cfg_reg;
    cfg_tog_next = cfg_tog_reg;
    lock_tog_next = lock_tog_reg;
    lock_addr_next = lock_addr_reg;
    if (ev_enter)
    begin
      cfg_next.quad_mode = 1'b1;
    end
    if (ev_exit)
    begin
      cfg_next.quad_mode = 1'b0;
    end
    if (ev_param)
    begin
      cfg_next.dummy_sel = ev_byte[`FSQ_PARAM_DUMMY_HI:`FSQ_PARAM_DUMMY_LO];
      cfg_next.wrap_sel = ev_byte[`FSQ_PARAM_WRAP_HI:`FSQ_PARAM_WRAP_LO];
    end
    if (ev_spiwrap)
    begin
      cfg_next.wrap_sel = ev_byte[`FSQ_SPIWRAP_HI:`FSQ_SPIWRAP_LO];
    end
    if (cfg_next != cfg_reg)
    begin
      cfg_tog_next = ~cfg_tog_reg;
    end
    if (ev_lock)
    begin
      lock_addr_next = sh_next;
      lock_tog_next = ~lock_tog_reg;
    end
  end

  always_ff @(posedge sclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cfg_reg <= '{dummy_sel: `FSQ_DUMMY_RESET, wrap_sel: `FSQ_WRAP_RESET, quad_mode: 1'b0};
      cfg_tog_reg <= 1'b0;
      lock_tog_reg <= 1'b0;
      lock_addr_reg <= 24'h00_0000;
    end
    else
    begin
      cfg_reg <= cfg_next;
      cfg_tog_reg <= cfg_tog_next;
      lock_tog_reg <= lock_tog_next;
      lock_addr_reg <= lock_addr_next;
    end
  end

  // -----------------------------------------------------------------------
  // output shifter on falling edges, msb first
  // -----------------------------------------------------------------------
  logic [3:0] io_next;
  logic [3:0] oe_next;

  always_comb
  begin
    io_next = 4'h0;
    oe_next = 4'h0;
    if (st_reg == fsq_pkg::ST_DATA_OUT)
    begin
      if (cfg_reg.quad_mode)
      begin
        io_next = cnt_reg[0] ? out_byte[3:0] : out_byte[7:4];
        oe_next = `FSQ_OE_QUAD;
      end
      else
      begin
        io_next = {2'h0, out_byte[3'(3'h7 - cnt_reg[2:0])], 1'b0};
        oe_next = `FSQ_OE_SPI;
      end
    end
  end

  always_ff @(negedge sclk_i or posedge frame_rst)
  begin
    if (frame_rst)
    begin
      io_o <= 4'h0;
      io_oe_o <= 4'h0;
    end
    else
    begin
      io_o <= io_next;
      io_oe_o <= oe_next;
    end
  end

  // -----------------------------------------------------------------------
  // core domain: toggles resynchronised, config and locks captured
  // -----------------------------------------------------------------------
  logic [2:0] cfg_tsync_reg;
  logic [2:0] lock_tsync_reg;
  logic [NUM_UNITS-1:0] lock_bits_reg, lock_bits_next;
  fsq_pkg::fsq_cfg_type core_cfg_reg, core_cfg_next;
  logic wp_next;

  // third stage only feeds the edge detect, never the first flop
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cfg_tsync_reg <= 3'h0;
      lock_tsync_reg <= 3'h0;
    end
    else
    begin
      cfg_tsync_reg <= {cfg_tsync_reg[1:0], cfg_tog_reg};
      lock_tsync_reg <= {lock_tsync_reg[1:0], lock_tog_reg};
    end
  end

  // data words are held still by the link until the next frame
  always_comb
  begin
    core_cfg_next = core_cfg_reg;
    lock_bits_next = lock_bits_reg;
    if (cfg_tsync_reg[2] != cfg_tsync_reg[1])
    begin
      core_cfg_next = cfg_reg;
    end
    if (lock_tsync_reg[2] != lock_tsync_reg[1])
    begin
      lock_bits_next[lock_addr_reg[`FSQ_ADDR_UNIT_LO +: UNIT_BITS]] = 1'b1;
    end
    // scheme select picks lock bits over the range protection result
    wp_next = protect_scheme_select_i ? lock_bits_reg[query_unit_i] : legacy_protect_i;
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      lock_bits_reg <= {NUM_UNITS{1'b1}};
      core_cfg_reg <= '{dummy_sel: `FSQ_DUMMY_RESET, wrap_sel: `FSQ_WRAP_RESET, quad_mode: 1'b0};
      write_protected_o <= 1'b1;
    end
    else
    begin
      lock_bits_reg <= lock_bits_next;
      core_cfg_reg <= core_cfg_next;
      write_protected_o <= wp_next;
    end
  end

  assign quad_command_mode_o = core_cfg_reg.quad_mode;
  assign dummy_count_field_o = core_cfg_reg.dummy_sel;
  assign wrap_size_field_o = core_cfg_reg.wrap_sel;

endmodule

// [hw/fsq_consts.svh]
// Purpose: named constants for the security/quad-mode/lock command block
// Assumes: included by bare name from the design file only
// Notes: opcodes, address fields, reset values and phase lengths
// Operation
// - program security register needs write enable latch
// - program 1..256 bytes, erased locations only
// - address selects register 1..3 and byte
// - otp lock bit set blocks programming
// - read: opcode, address, eight dummies, msb first
// - read byte address wraps FFh to 00h
// - security read ignored while device busy
// - set read parameters only in quad mode
// - dummy field selects 2, 4, 6, 8 clocks
// - wrap field selects 8, 16, 32, 64 bytes
// - reset gives 8-byte wrap and 2 dummies
// - spi wrap setting survives entry to quad mode
// - wrapped burst reads wrap inside aligned window
// - enter quad mode only with quad enable set
// - exit quad mode returns to spi operation
// - mode switch keeps latch, suspend, wrap length
// - individual lock needs latch, sets lock bit
// - lock bits count only with scheme select set
// - lock bits volatile, all set at reset
`ifndef FSQ_CONSTS_SVH
`define FSQ_CONSTS_SVH

// -----------------------------------------------------------------------
// opcodes
// -----------------------------------------------------------------------
`define FSQ_OP_PROG_SEC 8'h42
`define FSQ_OP_READ_SEC 8'h48
`define FSQ_OP_SET_PARAM 8'hC0
`define FSQ_OP_WRAP_SDR 8'h0C
`define FSQ_OP_WRAP_DTR 8'h0E
`define FSQ_OP_ENTER_QUAD 8'h38
`define FSQ_OP_EXIT_QUAD 8'hFF
`define FSQ_OP_LOCK 8'h36
`define FSQ_OP_SET_WRAP 8'h77

// -----------------------------------------------------------------------
// address fields, values, phase lengths
// -----------------------------------------------------------------------
`define FSQ_ADDR_TOP_HI 23
`define FSQ_ADDR_TOP_LO 16
`define FSQ_ADDR_SEL_HI 15
`define FSQ_ADDR_SEL_LO 12
`define FSQ_ADDR_ZERO_HI 11
`define FSQ_ADDR_ZERO_LO 8
`define FSQ_ADDR_BYTE_HI 7
`define FSQ_ADDR_BYTE_LO 0
`define FSQ_ADDR_UNIT_LO 16
`define FSQ_ERASED 8'hFF
`define FSQ_SEC_BYTES 9'h100
`define FSQ_SEC_DUMMY 6'h08
`define FSQ_BITS_OPCODE 6'h08
`define FSQ_BITS_ADDR 6'h18
`define FSQ_BITS_BYTE 6'h08
`define FSQ_DUMMY_RESET 2'h0
`define FSQ_WRAP_RESET 2'h0
`define FSQ_PARAM_DUMMY_HI 5
`define FSQ_PARAM_DUMMY_LO 4
`define FSQ_PARAM_WRAP_HI 1
`define FSQ_PARAM_WRAP_LO 0
`define FSQ_SPIWRAP_HI 5
`define FSQ_SPIWRAP_LO 4
`define FSQ_OE_SPI 4'h2
`define FSQ_OE_QUAD 4'hF

`endif

// [hw/fsq_pkg.sv]
// Purpose: types shared by the command block
// Assumes: constants come from fsq_consts.svh
// Notes: nothing here holds state
package fsq_pkg;

  // frame phases of the link-side interpreter
  typedef enum logic [2:0] {
    ST_OPCODE,
    ST_ADDR,
    ST_DUMMY,
    ST_DATA_IN,
    ST_DATA_OUT,
    ST_PARAM,
    ST_IGNORE
  } fsq_state_type;

  // commands that survive opcode decode
  typedef enum logic [2:0] {
    CMD_NONE,
    CMD_PROG_SEC,
    CMD_READ_SEC,
    CMD_WRAP_READ,
    CMD_LOCK,
    CMD_SET_PARAM,
    CMD_SET_WRAP
  } fsq_cmd_type;

  // read parameters, moved as one word across the clock boundary
  typedef struct packed {
    logic [1:0] dummy_sel;
    logic [1:0] wrap_sel;
    logic quad_mode;
  } fsq_cfg_type;

endpackage

// [verification/fsq_cmd_core_chk.sv]
// Purpose: port checks for the command block
// Assumes: lock bits are only ever set, never cleared
// Notes: all checks run on the core clock
`timescale 1ns/1ps
module fsq_cmd_core_chk (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // watched ports
  input wire logic cs_n_i,
  input wire logic [3:0] io_oe_o,
  input wire logic quad_enable_bit_i,
  input wire logic protect_scheme_select_i,
  input wire logic legacy_protect_i,
  input wire logic write_protected_o,
  input wire logic quad_command_mode_o,
  input wire logic [1:0] dummy_count_field_o,
  input wire logic [1:0] wrap_size_field_o
);
  // ------------------
  // checks
  // ------------------
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  property p_rst_cfg;
    $fell(rst_i) |-> !quad_command_mode_o && dummy_count_field_o == 2'h0 && wrap_size_field_o == 2'h0;
  endproperty
  a_rst_cfg: assert property (p_rst_cfg) else $error("config not at reset value");
  property p_prot_legacy;
    !protect_scheme_select_i |=> write_protected_o == $past(legacy_protect_i);
  endproperty
  a_prot_legacy: assert property (p_prot_legacy) else $error("range protection not followed");
  // no unlock exists here, so with the scheme on everything stays protected
  property p_prot_lock;
    protect_scheme_select_i |=> write_protected_o;
  endproperty
  a_prot_lock: assert property (p_prot_lock) else $error("lock bit lost");
  property p_cs_idle;
    cs_n_i |-> io_oe_o == 4'h0;
  endproperty
  a_cs_idle: assert property (p_cs_idle) else $error("driving while deselected");
  property p_oe_mode;
    io_oe_o != 4'h0 |-> io_oe_o == (quad_command_mode_o ? 4'hF : 4'h2);
  endproperty
  a_oe_mode: assert property (p_oe_mode) else $error("output lanes do not fit mode");
  property p_param_quad;
    $changed(dummy_count_field_o) |-> quad_command_mode_o && $past(quad_command_mode_o);
  endproperty
  a_param_quad: assert property (p_param_quad) else $error("dummy count set outside quad");
  property p_wrap_keep;
    $changed(quad_command_mode_o) |-> $stable(wrap_size_field_o);
  endproperty
  a_wrap_keep: assert property (p_wrap_keep) else $error("wrap changed on mode switch");
  property p_enter_qe;
    $rose(quad_command_mode_o) |-> quad_enable_bit_i;
  endproperty
  a_enter_qe: assert property (p_enter_qe) else $error("quad mode without enable");
endmodule

bind fsq_cmd_core fsq_cmd_core_chk chk_i (.ref_clk_i, .rst_i, .cs_n_i, .io_oe_o, .quad_enable_bit_i,
  .protect_scheme_select_i, .legacy_protect_i, .write_protected_o, .quad_command_mode_o,
  .dummy_count_field_o, .wrap_size_field_o);

// [verification/fsq_host_model.sv]
// Purpose: host controller model driving the serial link
// Assumes: serial clock idles low and runs only inside frames
// Notes: lines the host is not using toggle each clock
`timescale 1ns/1ps
module fsq_host_model (
  // link pins
  output logic sclk_o,
  output logic cs_n_o,
  output logic [3:0] io_o,
  // resolved link lines
  input wire logic [3:0] dev_io_i
);
  initial
  begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    io_o = 4'h0;
  end
  // ------------------
  // frames
  // ------------------
  // one clock; sample on the rise, the device changes on the fall
  task automatic pulse(output logic [3:0] s);
    #20 sclk_o = 1'b1;
    s = dev_io_i;
    #40 sclk_o = 1'b0;
    #20;
  endtask
  // bytes out msb first, dummy clocks, then nr bytes back
  task automatic frame(input bit q, input logic [7:0] tx[$], input int dm, input int nr,
    output logic [7:0] rx[$]);
    logic [3:0] s;
    logic [7:0] b;
    logic [7:0] t;
    int w;
    w = q ? 4 : 1;
    rx = {};
    #7 cs_n_o = 1'b0;
    foreach (tx[i])
    begin
      t = tx[i];
      for (int k = 0; k < 8; k += w)
      begin
        io_o = q ? t[7:4] : {~io_o[3:1], t[7]};
        t = t << w;
        pulse(s);
      end
    end
    repeat (dm)
    begin
      io_o = ~io_o;
      pulse(s);
    end
    repeat (nr)
    begin
      for (int k = 0; k < 8; k += w)
      begin
        io_o = ~io_o;
        pulse(s);
        b = q ? {b[3:0], s} : {b[6:0], s[1]};
      end
      rx.push_back(b);
    end
    #20 cs_n_o = 1'b1;
    io_o = ~io_o;
    #80;
  endtask
endmodule

// [verification/tb_fsq_cmd_core.sv]
// Purpose: self-checking bench for the command block
// Assumes: host model drives the link, bench drives status levels
// Notes: array data is address xor 5Ah so wrap order shows
`timescale 1ns/1ps
module tb_fsq_cmd_core;
  logic ref_clk_i, rst_i, write_enable_latch_flag, busy, qe, protect_scheme_select, legacy, prot, qm, sclk, cs_n, quad;
  logic [2:0] otp;
  logic [6:0] unit;
  logic [1:0] dum, wrap;
  logic [3:0] h_io, d_io, d_oe, io_w, oe_seen;
  logic [23:0] a_addr;
  logic [7:0] rx[$];
  logic [7:0] exp4[4] = '{8'hA5, 8'h3C, 8'h77, 8'hFF};
  logic [7:0] wops[2] = '{8'h0C, 8'h0E};
  int err_total, comparisons;
  // released lines carry the host pattern
  assign io_w = (d_oe & d_io) | (~d_oe & h_io);
  fsq_cmd_core fsq_cmd_core_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .sclk_i(sclk), .cs_n_i(cs_n),
    .io_i(io_w), .io_o(d_io), .io_oe_o(d_oe), .write_enable_latch_flag_i(write_enable_latch_flag), .busy_i(busy),
    .quad_enable_bit_i(qe), .otp_lock_bits_i(otp), .protect_scheme_select_i(protect_scheme_select),
    .legacy_protect_i(legacy), .array_addr_o(a_addr), .array_data_i(a_addr[7:0] ^ 8'h5A),
    .query_unit_i(unit), .write_protected_o(prot), .quad_command_mode_o(qm),
    .dummy_count_field_o(dum), .wrap_size_field_o(wrap));
  fsq_host_model fsq_host_model_i (.sclk_o(sclk), .cs_n_o(cs_n), .io_o(h_io), .dev_io_i(io_w));
  // ------------------
  // helpers
  // ------------------
  initial
  begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end
  // remember which lanes the device drove in a frame
  always @(posedge sclk) oe_seen = oe_seen | d_oe;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  task automatic stop_test();
    $display("comparisons=%0d err_total=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // core copies lag a frame by a few cycles, so wait before looking
  task automatic go(input bit q, input logic [7:0] tx[$], input int dm, input int nr);
    oe_seen = 4'h0;
    fsq_host_model_i.frame(q, tx, dm, nr, rx);
    repeat (6) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
  endtask
  // status passes synchronisers clocked by sclk, so clock an empty frame
  task automatic nop();
    go(quad, {8'h00}, 0, 0);
  endtask
  initial
  begin
    #1_000_000;
    err_total++;
    stop_test();
  end
  // ------------------
  // tests
  // ------------------
  initial
  begin
    rst_i = 1;
    write_enable_latch_flag = 1;
    busy = 0;
    qe = 0;
    otp = 3'h1;
    protect_scheme_select = 1;
    legacy = 0;
    unit = 7'h05;
    quad = 0;
    err_total = 0;
    comparisons = 0;
    oe_seen = 4'h0;
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 0;
    repeat (2) @(negedge ref_clk_i);
    chk({3'h0, qm, dum, wrap}, 8'h00);
    chk({7'h00, prot}, 8'h01);
    done("reset");
    go(0, {8'hC0, 8'h31}, 0, 0);
    chk({4'h0, dum, wrap}, 8'h00);
    go(0, {8'h42, 8'h00, 8'h20, 8'hFE, 8'hA5, 8'h3C, 8'h77}, 0, 0);
    go(0, {8'h42, 8'h00, 8'h20, 8'hFE, 8'h00}, 0, 0);
    go(0, {8'h42, 8'h00, 8'h10, 8'h00, 8'h12}, 0, 0);
    go(0, {8'h48, 8'h00, 8'h20, 8'hFE}, 8, 4);
    foreach (exp4[i]) chk(rx[i], exp4[i]);
    go(0, {8'h48, 8'h00, 8'h10, 8'h00}, 8, 1);
    chk(rx[0], 8'hFF);
    @(posedge ref_clk_i) write_enable_latch_flag <= 0;
    nop();
    go(0, {8'h42, 8'h00, 8'h30, 8'h10, 8'h55}, 0, 0);
    @(posedge ref_clk_i) busy <= 1;
    nop();
    go(0, {8'h48, 8'h00, 8'h30, 8'h10}, 8, 1);
    chk({4'h0, oe_seen}, 8'h00);
    @(posedge ref_clk_i) busy <= 0;
    nop();
    go(0, {8'h48, 8'h00, 8'h30, 8'h10}, 8, 1);
    chk(rx[0], 8'hFF);
    chk({4'h0, oe_seen}, 8'h02);
    // latch back on so the later lock command is a legal one
    @(posedge ref_clk_i) write_enable_latch_flag <= 1;
    done("security");
    go(0, {8'h38}, 0, 0);
    chk({7'h00, qm}, 8'h00);
    go(0, {8'h77, 8'h00, 8'h00, 8'h00, 8'h20}, 0, 0);
    @(posedge ref_clk_i) qe <= 1;
    nop();
    go(0, {8'h38}, 0, 0);
    quad = 1;
    chk({5'h00, qm, wrap}, 8'h06);
    for (int c = 0; c < 4; c++)
    begin
      go(1, {8'hC0, 8'(c * 16 + 3 - c)}, 0, 0);
      chk({4'h0, dum, wrap}, 8'(c * 4 + 3 - c));
    end
    foreach (wops[j])
    begin
      go(1, {wops[j], 8'h00, 8'h12, 8'h34}, 8, 6);
      for (int i = 0; i < 6; i++) chk(rx[i], (8'h30 | 8'((4 + i) % 8)) ^ 8'h5A);
    end
    done("quad");
    go(1, {8'h36, 8'h05, 8'h00, 8'h00}, 0, 0);
    chk({7'h00, prot}, 8'h01);
    @(posedge ref_clk_i) protect_scheme_select <= 0;
    repeat (2) @(negedge ref_clk_i);
    chk({7'h00, prot}, 8'h00);
    @(posedge ref_clk_i) legacy <= 1;
    repeat (2) @(negedge ref_clk_i);
    chk({7'h00, prot}, 8'h01);
    @(posedge ref_clk_i) protect_scheme_select <= 1;
    legacy <= 0;
    repeat (2) @(negedge ref_clk_i);
    chk({7'h00, prot}, 8'h01);
    done("lock");
    go(1, {8'hC0, 8'h31}, 0, 0);
    go(1, {8'hFF}, 0, 0);
    quad = 0;
    chk({5'h00, qm, wrap}, 8'h01);
    go(0, {8'h48, 8'h00, 8'h20, 8'hFF}, 8, 1);
    chk(rx[0], 8'h3C);
    // reset in mid-run must drop the non-default read parameters
    @(posedge ref_clk_i) rst_i <= 1;
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 0;
    repeat (2) @(negedge ref_clk_i);
    chk({3'h0, qm, dum, wrap}, 8'h00);
    done("exit");
    stop_test();
  end
endmodule
